// file: core/eprs_pin_sync.sv
// module: two-flop synchroniser with edge evaluation of the stable sample
`timescale 1ns/10ps
module eprs_pin_sync #(
	parameter int WIDTH = 6
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] fell,
	output logic [WIDTH-1:0] rose
);
	logic [WIDTH-1:0] meta_reg, meta_next;
	logic [WIDTH-1:0] sync_reg, sync_next;
	logic [WIDTH-1:0] prev_reg, prev_next;

	// idle pins are high, so reset to high to avoid a false falling edge
	always_comb begin
		meta_next = pin_in;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '1;
			sync_reg <= '1;
			prev_reg <= '1;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// only the second stage and later are evaluated
	always_comb begin
		level = sync_reg;
		fell = prev_reg & ~sync_reg;
		rose = ~prev_reg & sync_reg;
	end
endmodule : eprs_pin_sync

// file: core/eprs_top.sv
// module: sense selection and pending flags for six external request pins, Avalon-MM slave
//
// Summary of operation
// - 16-bit read/write sense select register
// - two bits per pin, upper bit first
// - mode 00: request while pin low
// - mode 01: request on falling edge
// - mode 10: request on rising edge
// - mode 11: request on either edge
// - reserved bits reset and read zero
// - 8-bit flag register, six pending flags
// - selected condition sets the pending flag
// - level mode: handled while high clears flag
// - edge modes: exception handling clears flag
// - transfer start with clear-select 0 clears
// - forward request only when enable set
// - software write of zero clears flag
// - detection independent of pin direction
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
module eprs_top #(
	parameter int NUM_PINS = eprs_pkg::NUM_PINS
) (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic [eprs_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic [NUM_PINS-1:0] EXT_REQUEST_PIN,
	input wire logic [NUM_PINS-1:0] EXC_HANDLED,
	input wire logic [NUM_PINS-1:0] XFER_START,
	input wire logic TRANSFER_CLEAR_SELECT,
	output logic [NUM_PINS-1:0] PIN_REQUEST,
	output logic IRQ_OUT
);
	eprs_pkg::eprs_bus_req_t req;
	eprs_pkg::eprs_service_t svc;
	logic [NUM_PINS-1:0] pin_level, pin_fell, pin_rose;

	logic [eprs_pkg::SENSE_W-1:0] sense_reg, sense_next;
	logic [NUM_PINS-1:0] flags_reg, flags_next;
	logic [NUM_PINS-1:0] enables_reg, enables_next;
	logic [eprs_pkg::IRQ_W-1:0] irq_stat_reg, irq_stat_next;
	logic [eprs_pkg::IRQ_W-1:0] irq_mask_reg, irq_mask_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;
	logic [NUM_PINS-1:0] req_out_reg, req_out_next;
	logic irq_reg, irq_next;
	logic [NUM_PINS-1:0] detect;
	logic [NUM_PINS-1:0] hw_clear;
	logic wr_sense, wr_flags, wr_enables, wr_stat, wr_mask;
	logic [31:0] wd;

	// detection compares synchronised samples only; pin direction is irrelevant here
	eprs_pin_sync #(
		.WIDTH(NUM_PINS)
	) u_sync (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.pin_in(EXT_REQUEST_PIN),
		.level(pin_level),
		.fell(pin_fell),
		.rose(pin_rose)
	);

	// byte-lane merge of write data into an existing register value
	function automatic logic [31:0] lane_merge(input logic [31:0] old_val, input logic [31:0] new_val,
		input logic [3:0] be);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	function automatic eprs_pkg::eprs_sense_t pin_mode(input logic [eprs_pkg::SENSE_W-1:0] s, input int p);
		return eprs_pkg::eprs_sense_t'(s[2*p +: 2]);
	endfunction : pin_mode

	always_comb begin
		req.address = AVS_ADDRESS;
		req.read = AVS_READ;
		req.write = AVS_WRITE;
		req.writedata = AVS_WRITEDATA;
		req.byteenable = AVS_BYTEENABLE;
		svc.handled = EXC_HANDLED;
		svc.xfer_start = XFER_START;
		svc.xfer_clear_sel = TRANSFER_CLEAR_SELECT;
	end

	// bus decode: one request is answered the cycle after it is seen;
	// a write commits on the answer edge, when the master samples waitrequest low
	always_comb begin
		wd = AVS_WRITEDATA & {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
			{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
		wr_sense = req.write && ack_reg && req.address == eprs_pkg::IDX_SENSE;
		wr_flags = req.write && ack_reg && req.address == eprs_pkg::IDX_FLAGS;
		wr_enables = req.write && ack_reg && req.address == eprs_pkg::IDX_ENABLES;
		wr_stat = req.write && ack_reg && req.address == eprs_pkg::IDX_IRQ_STATUS;
		wr_mask = req.write && ack_reg && req.address == eprs_pkg::IDX_IRQ_MASK;
	end

	// per-pin detection and hardware clearing
	always_comb begin
		for (int p = 0; p < NUM_PINS; p++) begin
			case (pin_mode(sense_reg, p))
				eprs_pkg::SENSE_LOW_LEVEL: begin
					detect[p] = ~pin_level[p];
					hw_clear[p] = svc.handled[p] & pin_level[p];
				end
				eprs_pkg::SENSE_FALLING: begin
					detect[p] = pin_fell[p];
					hw_clear[p] = svc.handled[p];
				end
				eprs_pkg::SENSE_RISING: begin
					detect[p] = pin_rose[p];
					hw_clear[p] = svc.handled[p];
				end
				eprs_pkg::SENSE_BOTH: begin
					detect[p] = pin_fell[p] | pin_rose[p];
					hw_clear[p] = svc.handled[p];
				end
				default: begin
					detect[p] = 1'b0;
					hw_clear[p] = 1'b0;
				end
			endcase
			if (svc.xfer_start[p] && !svc.xfer_clear_sel) begin
				hw_clear[p] = 1'b1;
			end
		end
	end

	// register file next state; a new detection wins over any clear in the same cycle
	always_comb begin
		logic [31:0] merged;
		merged = '0;
		sense_next = sense_reg;
		flags_next = flags_reg;
		enables_next = enables_reg;
		irq_stat_next = irq_stat_reg;
		irq_mask_next = irq_mask_reg;
		if (wr_sense) begin
			merged = lane_merge({16'h0000, sense_reg}, req.writedata, req.byteenable);
			sense_next = merged[eprs_pkg::SENSE_W-1:0] & eprs_pkg::SENSE_USED_MASK;
		end
		if (wr_enables) begin
			merged = lane_merge({26'h0000000, enables_reg}, req.writedata, req.byteenable);
			enables_next = merged[NUM_PINS-1:0];
		end
		if (wr_mask) begin
			merged = lane_merge({30'h00000000, irq_mask_reg}, req.writedata, req.byteenable);
			irq_mask_next = merged[eprs_pkg::IRQ_W-1:0];
		end
		// software may only clear flags: writing 0 clears, writing 1 keeps
		if (wr_flags && req.byteenable[0]) begin
			flags_next = flags_next & req.writedata[NUM_PINS-1:0];
		end
		flags_next = flags_next & ~hw_clear;
		flags_next = flags_next | detect;
		// event status, write one to clear, set wins
		if (wr_stat) begin
			irq_stat_next = irq_stat_next & ~wd[eprs_pkg::IRQ_W-1:0];
		end
		if (|detect) begin
			irq_stat_next[eprs_pkg::IRQ_BIT_FLAG_SET] = 1'b1;
		end
		if (|(flags_next & enables_next & ~req_out_reg)) begin
			irq_stat_next[eprs_pkg::IRQ_BIT_FORWARD] = 1'b1;
		end
	end

	// read path and outputs
	always_comb begin
		rdata_next = rdata_reg;
		ack_next = 1'b0;
		if ((req.read || req.write) && !ack_reg) begin
			ack_next = 1'b1;
			rdata_next = eprs_pkg::UNMAPPED_READ;
			if (req.read) begin
				case (req.address)
					eprs_pkg::IDX_SENSE: rdata_next = {16'h0000, sense_reg};
					eprs_pkg::IDX_FLAGS: rdata_next = {26'h0000000, flags_reg};
					eprs_pkg::IDX_ENABLES: rdata_next = {26'h0000000, enables_reg};
					eprs_pkg::IDX_IRQ_STATUS: rdata_next = {30'h00000000, irq_stat_reg};
					eprs_pkg::IDX_IRQ_MASK: rdata_next = {30'h00000000, irq_mask_reg};
					default: rdata_next = eprs_pkg::UNMAPPED_READ;
				endcase
			end
		end
		req_out_next = flags_next & enables_next;
		irq_next = |(irq_stat_next & irq_mask_next);
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			sense_reg <= eprs_pkg::SENSE_RESET;
			flags_reg <= eprs_pkg::FLAGS_RESET[NUM_PINS-1:0];
			enables_reg <= eprs_pkg::PINS_ZERO;
			irq_stat_reg <= eprs_pkg::IRQ_RESET;
			irq_mask_reg <= eprs_pkg::IRQ_RESET;
			rdata_reg <= eprs_pkg::UNMAPPED_READ;
			ack_reg <= 1'b0;
			req_out_reg <= eprs_pkg::PINS_ZERO;
			irq_reg <= 1'b0;
		end else begin
			sense_reg <= sense_next;
			flags_reg <= flags_next;
			enables_reg <= enables_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
			req_out_reg <= req_out_next;
			irq_reg <= irq_next;
		end
	end

	always_comb begin
		AVS_READDATA = rdata_reg;
		AVS_WAITREQUEST = ~ack_reg;
		PIN_REQUEST = req_out_reg;
		IRQ_OUT = irq_reg;
	end
endmodule : eprs_top

// file: pkg/eprs_pkg.sv
// package: register map, field layout and types for the external pin request sense block
package eprs_pkg;
	localparam int NUM_PINS = 6;
	localparam int SENSE_W = 16;
	localparam int FLAGS_W = 8;
	localparam int ADDR_W = 4;
	// word offsets (byte address = 4 x index)
	localparam logic [ADDR_W-1:0] IDX_SENSE = 4'h0;
	localparam logic [ADDR_W-1:0] IDX_FLAGS = 4'h1;
	localparam logic [ADDR_W-1:0] IDX_ENABLES = 4'h2;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 4'h3;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 4'h4;
	localparam logic [SENSE_W-1:0] SENSE_RESET = 16'h0000;
	localparam logic [SENSE_W-1:0] SENSE_USED_MASK = 16'h0FFF;
	localparam logic [FLAGS_W-1:0] FLAGS_RESET = 8'h00;
	localparam logic [FLAGS_W-1:0] FLAGS_USED_MASK = 8'h3F;
	localparam logic [NUM_PINS-1:0] PINS_ZERO = 6'h00;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
	// interrupt status bit layout
	localparam int IRQ_BIT_FLAG_SET = 0;
	localparam int IRQ_BIT_FORWARD = 1;
	localparam int IRQ_W = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

	typedef enum logic [1:0] {
		SENSE_LOW_LEVEL = 2'h0,
		SENSE_FALLING = 2'h1,
		SENSE_RISING = 2'h2,
		SENSE_BOTH = 2'h3
	} eprs_sense_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} eprs_bus_req_t;

	typedef struct packed {
		logic [NUM_PINS-1:0] handled;
		logic [NUM_PINS-1:0] xfer_start;
		logic xfer_clear_sel;
	} eprs_service_t;
endpackage : eprs_pkg

// file: sim/eprs_far_model.sv
// far side model: request pins and service strobes from the interrupt and transfer controllers
`timescale 1ns/10ps
module eprs_far_model (
	input wire logic clk,
	input wire logic [5:0] pin_cmd,
	input wire eprs_pkg::eprs_service_t svc_cmd,
	output logic [5:0] pins = 6'h3F,
	output eprs_pkg::eprs_service_t svc = '0
);
	always_ff @(posedge clk) begin
		pins <= pin_cmd;
		svc <= svc_cmd;
	end
endmodule : eprs_far_model

// file: sim/eprs_top_props.sv
// checker: bus answer, reserved bits, flag set and clear timing, interrupt release
`timescale 1ns/10ps
module eprs_top_props #(
	parameter int NUM_PINS = 6
) (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic [NUM_PINS-1:0] EXT_REQUEST_PIN,
	input wire logic [NUM_PINS-1:0] EXC_HANDLED,
	input wire logic [NUM_PINS-1:0] XFER_START,
	input wire logic TRANSFER_CLEAR_SELECT,
	input wire logic [NUM_PINS-1:0] PIN_REQUEST,
	input wire logic IRQ_OUT
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// pin 0 history; quiet means no detection can still be in flight
	logic [6:0] hist_reg;
	logic quiet0;
	always_ff @(posedge CLK_SYS) begin
		hist_reg <= SYS_RST ? 7'h00 : {hist_reg[5:0], EXT_REQUEST_PIN[0]};
	end
	assign quiet0 = (&hist_reg) & EXT_REQUEST_PIN[0];
	a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low longer than one cycle");
	a_req_answered: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST)
		else $error("request not answered");
	a_sense_rsvd: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == eprs_pkg::IDX_SENSE
		|-> AVS_READDATA[31:12] == 20'h00000) else $error("reserved sense bits not zero");
	a_set_cause: assert property ($rose(PIN_REQUEST[0]) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2) || !(&hist_reg))
		else $error("request raised without pin activity");
	a_handled_clr: assert property (EXC_HANDLED[0] && quiet0 |=> !PIN_REQUEST[0])
		else $error("handling did not clear request");
	a_xfer_clr: assert property (XFER_START[0] && !TRANSFER_CLEAR_SELECT && quiet0 |=> !PIN_REQUEST[0])
		else $error("transfer start did not clear request");
	a_xfer_keep: assert property (XFER_START[2] && TRANSFER_CLEAR_SELECT && PIN_REQUEST[2] && !EXC_HANDLED[2]
		&& !AVS_WRITE |=> PIN_REQUEST[2]) else $error("clear-select 1 cleared request");
	a_irq_release: assert property ($fell(IRQ_OUT) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2))
		else $error("interrupt dropped without a write");
endmodule : eprs_top_props
bind eprs_top eprs_top_props #(.NUM_PINS(NUM_PINS)) u_props (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_REQUEST_PIN(EXT_REQUEST_PIN), .EXC_HANDLED(EXC_HANDLED),
	.XFER_START(XFER_START), .TRANSFER_CLEAR_SELECT(TRANSFER_CLEAR_SELECT), .PIN_REQUEST(PIN_REQUEST),
	.IRQ_OUT(IRQ_OUT));

// file: sim/eprs_top_tb_top.sv
// testbench: register, sensing, service and interrupt tests
`timescale 1ns/10ps
module eprs_top_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic wait_req;
	logic [5:0] pin_cmd = 6'h3F;
	eprs_pkg::eprs_service_t svc_cmd = '0;
	logic [5:0] pins;
	eprs_pkg::eprs_service_t svc;
	logic [5:0] preq;
	logic irq;
	int bad_count = 0;
	int cmp_count = 0;
	logic [31:0] rd;
	logic [15:0] sense;
	logic [5:0] fall_exp;
	logic [5:0] rise_exp;
	always #2.5 clk = ~clk;
	eprs_far_model far_u (.clk(clk), .pin_cmd(pin_cmd), .svc_cmd(svc_cmd), .pins(pins), .svc(svc));
	eprs_top dut_u (.CLK_SYS(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
		.AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
		.EXT_REQUEST_PIN(pins), .EXC_HANDLED(svc.handled), .XFER_START(svc.xfer_start),
		.TRANSFER_CLEAR_SELECT(svc.xfer_clear_sel), .PIN_REQUEST(preq), .IRQ_OUT(irq));
	// no local limit: a slave that never answers is caught by the watchdog
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wr_en <= wr;
		rd_en <= ~wr;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (wait_req !== 1'b0);
		rd = rdat;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask : bus
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h00000000);
		chk(rd, e);
	endtask : rdchk
	task automatic service(input logic [5:0] h, input logic [5:0] x, input logic s);
		@(posedge clk);
		svc_cmd <= '{h, x, s};
		@(posedge clk);
		svc_cmd <= '0;
	endtask : service
	task automatic print_verdict();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	// whole run is about 350 cycles
	initial begin
		#40000;
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdchk(eprs_pkg::IDX_FLAGS, 32'h00000000);
		bus(1'b1, eprs_pkg::IDX_SENSE, 32'h00000FFF);
		rdchk(eprs_pkg::IDX_SENSE, 32'h00000FFF);
		bus(1'b1, 4'h7, 32'hFFFFFFFF);
		rdchk(4'h7, 32'h00000000);
		bus(1'b1, eprs_pkg::IDX_ENABLES, 32'h00000015);
		rdchk(eprs_pkg::IDX_ENABLES, 32'h00000015);
		for (int m = 0; m < 4; m++) begin
			sense = 16'h0000;
			for (int p = 0; p < 6; p++) begin
				sense[2*p+:2] = 2'(m + p);
				fall_exp[p] = (2'(m + p) != 2'h2);
				rise_exp[p] = (2'(m + p) != 2'h1);
			end
			bus(1'b1, eprs_pkg::IDX_SENSE, {16'h0000, sense});
			idle_pins(6'h3F);
			bus(1'b1, eprs_pkg::IDX_FLAGS, 32'h00000000);
			bus(1'b1, eprs_pkg::IDX_FLAGS, 32'h0000003F);
			rdchk(eprs_pkg::IDX_FLAGS, 32'h00000000);
			idle_pins(6'h00);
			rdchk(eprs_pkg::IDX_FLAGS, {26'h0, fall_exp});
			chk({26'h0, preq}, {26'h0, fall_exp & 6'h15});
			bus(1'b1, eprs_pkg::IDX_FLAGS, 32'h00000000);
			idle_pins(6'h3F);
			rdchk(eprs_pkg::IDX_FLAGS, {26'h0, rise_exp});
		end
		// pin 3 in level mode stays low so its handling must not clear it
		bus(1'b1, eprs_pkg::IDX_SENSE, 32'h00000F3F);
		idle_pins(6'h00);
		idle_pins(6'h37);
		service(6'h09, 6'h00, 1'b0);
		// set pin 0 again so the transfer start has a live flag to clear
		idle_pins(6'h36);
		idle_pins(6'h37);
		service(6'h00, 6'h03, 1'b0);
		service(6'h00, 6'h04, 1'b1);
		rdchk(eprs_pkg::IDX_FLAGS, 32'h0000003C);
		idle_pins(6'h3F);
		chk({31'h0, irq}, 32'h00000000);
		rdchk(eprs_pkg::IDX_IRQ_STATUS, 32'h00000003);
		bus(1'b1, eprs_pkg::IDX_IRQ_MASK, 32'h00000003);
		rdchk(eprs_pkg::IDX_IRQ_MASK, 32'h00000003);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h00000001);
		bus(1'b1, eprs_pkg::IDX_IRQ_STATUS, 32'h00000003);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h00000000);
		rdchk(eprs_pkg::IDX_IRQ_STATUS, 32'h00000000);
		print_verdict();
	end
	task automatic idle_pins(input logic [5:0] v);
		pin_cmd <= v;
		repeat (12) @(posedge clk);
	endtask : idle_pins
endmodule : eprs_top_tb_top
